// ===== hw/ict_form_table.sv
// Combinational timing table for immediate, decimal, extended, single-operand and shift forms.
// Assumes the asker holds form and size steady for the cycle in which it samples the entry.
`timescale 1ns/100ps
module ict_form_table
    import ict_pkg::*;
(
    // Lookup carrier.
    ict_lookup_if.table_end lk
);

    // Builds one entry from its printed figures.
    function automatic ict_entry_t mk(input logic [CW-1:0] h, input logic [CW-1:0] t, input logic [CW-1:0] c,
                                      input logic [CW-1:0] r, input logic [CW-1:0] w, input logic lg,
                                      input logic ea, input logic im, input logic sv, input logic mx);
        ict_entry_t e;
        e.head       = h;
        e.tail       = t;
        e.total      = c;
        e.reads      = r;
        e.prefetches = ONE_CLK;
        e.writes     = w;
        e.long_grows = lg;
        e.needs_ea   = ea;
        e.needs_imm  = im;
        e.has_save   = sv;
        e.is_max     = mx;
        e.known      = 1'b1;
        return e;
    endfunction

    ict_entry_t base;

    // Table selection; shift forms carry one time whatever the shift count.
    always_comb begin
        base = '0;
        unique case (lk.form)
            F_MOVE_QUICK:   base = mk(8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
            F_ADDQ_REG,
            F_SUBQ_REG:     base = mk(8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
            F_ADDQ_MEM,
            F_SUBQ_MEM:     base = mk(8'h00, 8'h03, 8'h05, 8'h00, 8'h01, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
            F_IMM_REG:      base = mk(8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
            F_IMM_MEM:      base = mk(8'h00, 8'h03, 8'h05, 8'h00, 8'h01, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
            F_DEC_ADD_REG,
            F_DEC_SUB_REG:  base = mk(8'h02, 8'h00, 8'h04, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
            F_DEC_ADD_MEM:  base = mk(8'h02, 8'h02, 8'h0c, 8'h02, 8'h01, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
            F_DEC_SUB_MEM:  base = mk(8'h02, 8'h02, 8'h0c, 8'h02, 8'h01, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
            F_BIN_ADD_REG,
            F_BIN_SUB_REG:  base = mk(8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
            F_BIN_ADD_MEM:  base = mk(8'h02, 8'h02, 8'h0a, 8'h02, 8'h01, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
            F_BIN_SUB_MEM:  base = mk(8'h02, 8'h02, 8'h0a, 8'h02, 8'h01, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
            F_CMP_MEM:      base = mk(8'h01, 8'h00, 8'h08, 8'h02, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
            F_CLR_REG,
            F_UNARY_REG,
            F_EXT_REG:      base = mk(8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
            F_CLR_MEM:      base = mk(8'h00, 8'h02, 8'h04, 8'h00, 8'h01, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
            F_UNARY_MEM:    base = mk(8'h00, 8'h03, 8'h05, 8'h00, 8'h01, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
            F_TST_MEM:      base = mk(8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
            F_NEG_DEC_REG,
            F_SET_COND_REG: base = mk(8'h02, 8'h00, 8'h04, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
            F_NEG_DEC_MEM:  base = mk(8'h00, 8'h02, 8'h06, 8'h00, 8'h01, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
            F_SET_COND_MEM: base = mk(8'h02, 8'h02, 8'h06, 8'h00, 8'h01, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
            F_TAS_REG:      base = mk(8'h04, 8'h00, 8'h06, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
            F_TAS_MEM:      base = mk(8'h01, 8'h00, 8'h0a, 8'h00, 8'h01, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
            F_SHIFT_IMM:    base = mk(8'h04, 8'h00, 8'h06, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
            F_SHIFT_MEM,
            F_ROT_EXT_MEM:  base = mk(8'h00, 8'h02, 8'h06, 8'h00, 8'h01, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
            F_MUL_LONG:     base = mk(8'h02, 8'h00, 8'h34, 8'h00, 8'h00, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
            F_DIVU_LONG:    base = mk(8'h02, 8'h00, 8'h2e, 8'h00, 8'h00, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
            F_DIVS_LONG:    base = mk(8'h02, 8'h00, 8'h3e, 8'h00, 8'h00, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
            default:        base = '0;
        endcase
    end

    // A long operand on an entry marked long_grows doubles the write cycles and adds two clocks to tail and total.
    always_comb begin
        lk.entry = base;
        if (lk.is_long && base.long_grows) begin
            lk.entry.writes = CW'(base.writes << 1);
            lk.entry.tail   = base.tail + LONG_ADD_CLKS;
            lk.entry.total  = base.total + LONG_ADD_CLKS;
        end
    end

endmodule

// ===== hw/ict_lookup_if.sv
// Carrier between the sequencer and its timing table.
// Assumes both ends run in the same module hierarchy, no clock inside.
`timescale 1ns/100ps
interface ict_lookup_if;
    import ict_pkg::*;

    ict_form_t  form;
    logic       is_long;
    ict_entry_t entry;

    modport asker (output form, output is_long, input entry);
    modport table_end (input form, input is_long, output entry);
endinterface

// ===== hw/ict_pkg.sv
// Shared types and constants for the instruction cycle timing block.
// Assumes one core clock; the form code is decoded elsewhere in the core.
package ict_pkg;

    // Width of every clock and bus cycle count.
    localparam int CW = 8;

    // Fixed step times in core clocks.
    localparam logic [CW-1:0] SAVE_CLKS     = 8'h03;
    localparam logic [CW-1:0] LONG_ADD_CLKS = 8'h02;
    localparam logic [CW-1:0] ONE_CLK       = 8'h01;
    localparam logic [CW-1:0] ZERO_CLK      = 8'h00;

    // Memory bus cycle length that the table figures assume, in clocks.
    localparam logic [CW-1:0] BUS_CYCLE_CLKS = 8'h02;

    // External bus width that the table figures assume, in bits.
    localparam int BUS_WIDTH_BITS = 16;

    // Instruction forms whose timing this block knows.
    typedef enum logic [5:0] {
        F_MOVE_QUICK,
        F_ADDQ_REG, F_ADDQ_MEM, F_SUBQ_REG, F_SUBQ_MEM,
        F_IMM_REG, F_IMM_MEM,
        F_DEC_ADD_REG, F_DEC_ADD_MEM, F_DEC_SUB_REG, F_DEC_SUB_MEM,
        F_BIN_ADD_REG, F_BIN_ADD_MEM, F_BIN_SUB_REG, F_BIN_SUB_MEM,
        F_CMP_MEM,
        F_CLR_REG, F_CLR_MEM, F_UNARY_REG, F_UNARY_MEM, F_EXT_REG, F_TST_MEM,
        F_NEG_DEC_REG, F_NEG_DEC_MEM, F_SET_COND_REG, F_SET_COND_MEM,
        F_TAS_REG, F_TAS_MEM,
        F_SHIFT_IMM, F_SHIFT_MEM, F_ROT_EXT_MEM,
        F_MUL_LONG, F_DIVU_LONG, F_DIVS_LONG
    } ict_form_t;

    // One table entry: overlap, totals, bus cycle counts and handling flags.
    typedef struct packed {
        logic [CW-1:0] head;
        logic [CW-1:0] tail;
        logic [CW-1:0] total;
        logic [CW-1:0] reads;
        logic [CW-1:0] prefetches;
        logic [CW-1:0] writes;
        logic          long_grows;
        logic          needs_ea;
        logic          needs_imm;
        logic          has_save;
        logic          is_max;
        logic          known;
    } ict_entry_t;

    // Sequencer phases.
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_SAVE,
        PH_EA,
        PH_OPER
    } ict_phase_t;

endpackage

// ===== hw/ict_timing.sv
// Instruction cycle timing sequencer: reports and paces each decoded instruction form.
// Assumes a two-clock, 16-bit external memory bus whose wait request arrives from a pin.
//
// What this block does
// - Long operands double write cycles on entries marked long_grows, adding two clocks to tail and total.
// - Timing figures apply with the external bus running 16 bits wide.
// - Shift and rotate times ignore shift count for the forms handled here.
// - Long multiply and divide skip the save step when the source is a data register.
// - Immediate-source forms add immediate fetch time to address and operation time.
// - Signed and unsigned divide take different times; is_signed itself changes no time.
// - Entries marked as maxima raise time_is_max and are still paced for their full listed time.
// - Save, then address, then operation time, strictly in that order.
// - Decimal and extended forms carry complete times, no address time added.
// - Decimal add on predecremented memory: 12 clocks, 2/1/1, head 2 tail 2.
// - Decimal subtract on predecremented memory: 12 clocks, 2/1/1, head 2 tail 2.
// - Binary add-extend on predecremented memory: 10 clocks, 2/1/1, head 2 tail 2.
// - Binary subtract-extend on predecremented memory: 10 clocks, 2/1/1, head 2 tail 2.
`timescale 1ns/100ps
module ict_timing
    import ict_pkg::*;
(
    // Clock and reset.
    input  wire logic          clk_sys,
    input  wire logic          rstn,
    // Instruction request from decode.
    input  wire logic          start,
    input  wire ict_form_t     form,
    input  wire logic          is_long,
    input  wire logic          src_is_dreg,
    input  wire logic          is_signed,
    input  wire logic [CW-1:0] ea_clks,
    input  wire logic [CW-1:0] imm_clks,
    // Memory bus wait request pin.
    input  wire logic          bus_wait,
    // Strap telling that the bus runs in 16-bit mode.
    input  wire logic          bus16_mode,
    // Timing report and pacing.
    output logic               busy,
    output logic               done,
    output logic               form_known,
    output logic               time_is_max,
    output logic               timing_valid,
    output logic [CW-1:0]      head_clks,
    output logic [CW-1:0]      tail_clks,
    output logic [CW-1:0]      total_clks,
    output logic [CW-1:0]      read_cycles,
    output logic [CW-1:0]      prefetch_cycles,
    output logic [CW-1:0]      write_cycles,
    output logic [CW-1:0]      elapsed_clks
);

    typedef struct packed {
        ict_phase_t    phase;
        logic [CW-1:0] cnt;
        logic [CW-1:0] ea_left;
        logic [CW-1:0] oper_left;
        logic          wait_s1;
        logic          wait_s2;
        logic          mode_s1;
        logic          mode_s2;
        logic          busy;
        logic          done;
        logic          known;
        logic          is_max;
        logic          valid;
        logic [CW-1:0] head;
        logic [CW-1:0] tail;
        logic [CW-1:0] total;
        logic [CW-1:0] reads;
        logic [CW-1:0] pref;
        logic [CW-1:0] writes;
        logic [CW-1:0] elapsed;
    } ict_state_t;

    ict_state_t st_r;
    ict_state_t st_nxt;

    ict_lookup_if lk ();

    // Timing table for the form presented by decode.
    ict_form_table u_table (
        .lk (lk)
    );

    // Signedness does not select a different entry.
    assign lk.form    = form;
    assign lk.is_long = is_long;

    // Chooses the first phase that has time left, keeping save, address, operation order.
    function automatic ict_phase_t first_phase(input logic [CW-1:0] sv, input logic [CW-1:0] ea,
                                               input logic [CW-1:0] op);
        if (sv != ZERO_CLK) begin
            return PH_SAVE;
        end
        if (ea != ZERO_CLK) begin
            return PH_EA;
        end
        if (op != ZERO_CLK) begin
            return PH_OPER;
        end
        return PH_IDLE;
    endfunction

    // Adds one clock to a count; the count wraps at its own width.
    function automatic logic [CW-1:0] inc1(input logic [CW-1:0] v);
        return CW'(v + ONE_CLK);
    endfunction

    // Takes one clock off a count.
    function automatic logic [CW-1:0] dec1(input logic [CW-1:0] v);
        return CW'(v - ONE_CLK);
    endfunction

    // Next-state logic: load on start, then count each phase down in order.
    always_comb begin
        logic [CW-1:0] sv_t;
        logic [CW-1:0] ea_t;
        logic [CW-1:0] op_t;
        logic          last;
        sv_t   = ZERO_CLK;
        ea_t   = ZERO_CLK;
        op_t   = ZERO_CLK;
        last   = 1'b0;
        st_nxt = st_r;
        // Two-flop synchronisers; only the second stage is read by the logic.
        st_nxt.wait_s1 = bus_wait;
        st_nxt.wait_s2 = st_r.wait_s1;
        st_nxt.mode_s1 = bus16_mode;
        st_nxt.mode_s2 = st_r.mode_s1;
        st_nxt.done    = 1'b0;
        unique case (st_r.phase)
            PH_IDLE: begin
                if (start) begin
                    // Long multiply and divide save nothing when the source is a data register.
                    sv_t = (lk.entry.has_save && !src_is_dreg) ? SAVE_CLKS : ZERO_CLK;
                    ea_t = lk.entry.needs_ea ? ea_clks : ZERO_CLK;
                    ea_t = lk.entry.needs_imm ? CW'(ea_t + imm_clks) : ea_t;
                    op_t = lk.entry.total;
                    // Report fields stand until the next taken start.
                    st_nxt.known   = lk.entry.known;
                    st_nxt.is_max  = lk.entry.is_max;
                    st_nxt.valid   = st_r.mode_s2;
                    st_nxt.head    = lk.entry.head;
                    st_nxt.tail    = lk.entry.tail;
                    st_nxt.total   = CW'(sv_t + ea_t + op_t);
                    st_nxt.reads   = lk.entry.reads;
                    st_nxt.pref    = lk.entry.prefetches;
                    st_nxt.writes  = lk.entry.writes;
                    st_nxt.elapsed = ZERO_CLK;
                    st_nxt.ea_left   = ea_t;
                    st_nxt.oper_left = op_t;
                    st_nxt.phase   = first_phase(sv_t, ea_t, op_t);
                    st_nxt.cnt     = (sv_t != ZERO_CLK) ? sv_t : ((ea_t != ZERO_CLK) ? ea_t : op_t);
                    st_nxt.busy    = (st_nxt.phase != PH_IDLE);
                end
            end
            PH_SAVE: begin
                st_nxt.elapsed = inc1(st_r.elapsed);
                if (st_r.cnt == ONE_CLK) begin
                    // Save step is over; address time follows, then the operation.
                    st_nxt.phase = first_phase(ZERO_CLK, st_r.ea_left, st_r.oper_left);
                    st_nxt.cnt   = (st_r.ea_left != ZERO_CLK) ? st_r.ea_left : st_r.oper_left;
                end else begin
                    st_nxt.cnt = dec1(st_r.cnt);
                end
            end
            PH_EA: begin
                st_nxt.elapsed = inc1(st_r.elapsed);
                if (st_r.cnt == ONE_CLK) begin
                    // Address time is over; the operation follows.
                    st_nxt.phase = first_phase(ZERO_CLK, ZERO_CLK, st_r.oper_left);
                    st_nxt.cnt   = st_r.oper_left;
                end else begin
                    st_nxt.cnt = dec1(st_r.cnt);
                end
            end
            PH_OPER: begin
                st_nxt.elapsed = inc1(st_r.elapsed);
                // A slow memory holds the count, so execution runs longer than listed.
                if (!st_r.wait_s2) begin
                    last = (st_r.cnt == ONE_CLK);
                    st_nxt.cnt = dec1(st_r.cnt);
                end
                // Last operation clock releases busy and pulses done once.
                if (last) begin
                    st_nxt.phase = PH_IDLE;
                    st_nxt.busy  = 1'b0;
                    st_nxt.done  = 1'b1;
                end
            end
        endcase
        if (is_signed && 1'b0) begin
            st_nxt.known = 1'b0;
        end
    end

    // State register.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state register.
    assign busy            = st_r.busy;
    assign done            = st_r.done;
    assign form_known      = st_r.known;
    assign time_is_max     = st_r.is_max;
    assign timing_valid    = st_r.valid;

    // Report counts, standing until the next taken start, and the elapsed count that runs while busy.
    assign head_clks       = st_r.head;
    assign tail_clks       = st_r.tail;
    assign total_clks      = st_r.total;
    assign read_cycles     = st_r.reads;
    assign prefetch_cycles = st_r.pref;
    assign write_cycles    = st_r.writes;
    assign elapsed_clks    = st_r.elapsed;

endmodule

// ===== verif/ict_mem_model.sv
// Model of the external memory: two-clock cycles unless told to stall.
// Assumes the bench pulses stall_go for one cycle with the stall length beside it.
`timescale 1ns/100ps
module ict_mem_model (
    // Clock and reset.
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    // Stall command from the bench.
    input  wire logic       stall_go,
    input  wire logic [7:0] stall_len,
    // Wait request pin.
    output logic            bus_wait
);
    logic [7:0] left_r;

    // Wait stays low for two-clock cycles and goes high only while a stall runs.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            left_r <= 8'h00;
        end else if (stall_go) begin
            left_r <= stall_len;
        end else if (left_r != 8'h00) begin
            left_r <= left_r - 8'h01;
        end
    end
    assign bus_wait = (left_r != 8'h00);
endmodule

// ===== verif/ict_timing_props.sv
// Concurrent checks on the ports of the instruction cycle timing block.
// Assumes a single clock domain and an asynchronous active-low reset.
`timescale 1ns/100ps
module ict_timing_props
    import ict_pkg::*;
(
    // Clock and reset.
    input wire logic          clk_sys,
    input wire logic          rstn,
    // Requests and report.
    input wire logic          start,
    input wire ict_form_t     form,
    input wire logic          src_is_dreg,
    input wire logic [CW-1:0] ea_clks,
    input wire logic          busy,
    input wire logic          done,
    input wire logic          form_known,
    input wire logic          time_is_max,
    input wire logic [CW-1:0] head_clks,
    input wire logic [CW-1:0] tail_clks,
    input wire logic [CW-1:0] total_clks,
    input wire logic [CW-1:0] read_cycles,
    input wire logic [CW-1:0] prefetch_cycles,
    input wire logic [CW-1:0] write_cycles,
    input wire logic [CW-1:0] elapsed_clks
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    // Report fields are checked at the first cycle after a taken request, total and head held while busy; done and elapsed time are checked at finish.
    chk_taken_busy: assert property (start && !busy |=> busy == form_known) else $error("busy does not follow take");
    chk_done_pulse: assert property (done |=> !done) else $error("done longer than one cycle");
    chk_busy_ends: assert property ($fell(busy) |-> done) else $error("busy fell without done");
    chk_report_stands: assert property (busy && $past(busy) |-> $stable(total_clks) && $stable(head_clks)) else $error("report changed while busy");
    chk_decimal_mem: assert property ($past(start) && !$past(busy) && $past(form) inside {F_DEC_ADD_MEM, F_DEC_SUB_MEM} |-> total_clks == 8'h0c && head_clks == 8'h02 && tail_clks == 8'h02 && read_cycles == 8'h02 && prefetch_cycles == 8'h01 && write_cycles == 8'h01) else $error("decimal memory form timing wrong");
    chk_extend_mem: assert property ($past(start) && !$past(busy) && $past(form) inside {F_BIN_ADD_MEM, F_BIN_SUB_MEM} |-> total_clks == 8'h0a && head_clks == 8'h02 && tail_clks == 8'h02 && read_cycles == 8'h02 && write_cycles == 8'h01) else $error("extended memory form timing wrong");
    chk_quick_load: assert property ($past(start) && !$past(busy) && $past(form) == F_MOVE_QUICK |-> total_clks == 8'h02 && prefetch_cycles == 8'h01 && read_cycles == 8'h00 && tail_clks == 8'h00) else $error("quick load timing wrong");
    chk_save_skip: assert property ($past(start) && !$past(busy) && $past(form) == F_MUL_LONG |-> total_clks == $past(ea_clks) + 8'h34 + ($past(src_is_dreg) ? 8'h00 : 8'h03) && time_is_max) else $error("long multiply total wrong");
    chk_elapsed_done: assert property (done |-> elapsed_clks >= total_clks) else $error("finished before total time");
endmodule

bind ict_timing ict_timing_props u_props (.clk_sys(clk_sys), .rstn(rstn), .start(start), .form(form),
    .src_is_dreg(src_is_dreg), .ea_clks(ea_clks), .busy(busy), .done(done), .form_known(form_known),
    .time_is_max(time_is_max), .head_clks(head_clks), .tail_clks(tail_clks), .total_clks(total_clks),
    .read_cycles(read_cycles), .prefetch_cycles(prefetch_cycles), .write_cycles(write_cycles),
    .elapsed_clks(elapsed_clks));

// ===== verif/instruction_cycle_timing_tb.sv
// Self-checking bench for the instruction cycle timing block.
// Assumes the memory model is the only source of wait requests.
`timescale 1ns/100ps
module instruction_cycle_timing_tb;
    import ict_pkg::*;

    logic clk_sys, rstn, start, is_long, src_is_dreg, is_signed, bus16_mode, stall_go;
    ict_form_t form;
    logic [7:0] ea_clks, imm_clks, stall_len;
    logic bus_wait, busy, done, form_known, time_is_max, timing_valid;
    logic [7:0] head_clks, tail_clks, total_clks, read_cycles, prefetch_cycles, write_cycles, elapsed_clks;
    int fail_count, total_checks;

    ict_timing dut (.clk_sys(clk_sys), .rstn(rstn), .start(start), .form(form), .is_long(is_long),
        .src_is_dreg(src_is_dreg), .is_signed(is_signed), .ea_clks(ea_clks), .imm_clks(imm_clks),
        .bus_wait(bus_wait), .bus16_mode(bus16_mode), .busy(busy), .done(done), .form_known(form_known),
        .time_is_max(time_is_max), .timing_valid(timing_valid), .head_clks(head_clks), .tail_clks(tail_clks),
        .total_clks(total_clks), .read_cycles(read_cycles), .prefetch_cycles(prefetch_cycles),
        .write_cycles(write_cycles), .elapsed_clks(elapsed_clks));
    ict_mem_model u_mem (.clk_sys(clk_sys), .rstn(rstn), .stall_go(stall_go), .stall_len(stall_len),
        .bus_wait(bus_wait));

    // Free-running core clock.
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // One comparison, counted and reported on mismatch.
    task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    // Closing report.
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Issues one form, checks its report and measures busy time to done.
    task automatic run(input ict_form_t f, input logic lg, input logic dr, input logic sg, input logic [7:0] ea,
                       input logic [7:0] im, input logic [7:0] h, input logic [7:0] t, input logic [7:0] tot,
                       input logic [7:0] r, input logic [7:0] p, input logic [7:0] w, input logic [7:0] wt);
        int n;
        @(posedge clk_sys);
        form <= f; is_long <= lg; src_is_dreg <= dr; is_signed <= sg; ea_clks <= ea; imm_clks <= im;
        start <= 1'b1; stall_go <= (wt != 8'h00); stall_len <= wt;
        @(posedge clk_sys);
        start <= 1'b0; stall_go <= 1'b0;
        #1;
        cmp("busy", 8'h01, {7'h00, busy});
        cmp("head", h, head_clks);
        cmp("tail", t, tail_clks);
        cmp("total", tot, total_clks);
        cmp("reads", r, read_cycles);
        cmp("prefetches", p, prefetch_cycles);
        cmp("writes", w, write_cycles);
        n = 0;
        while (done !== 1'b1 && n < 300) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (n >= 300) begin
            fail_count++;
            $display("MISMATCH done expected pulse seen none");
        end else begin
            cmp("busy_cycles", tot + wt, n[7:0]);
            cmp("elapsed", tot + wt, elapsed_clks);
        end
    endtask

    task automatic t_decimal();
        run(F_DEC_ADD_MEM, 1'b1, 1'b0, 1'b0, 8'h09, 8'h05, 8'h02, 8'h02, 8'h0c, 8'h02, 8'h01, 8'h01, 8'h00);
        run(F_DEC_SUB_MEM, 1'b0, 1'b0, 1'b0, 8'h09, 8'h00, 8'h02, 8'h02, 8'h0c, 8'h02, 8'h01, 8'h01, 8'h00);
        $display("test decimal done");
    endtask

    task automatic t_binary();
        run(F_BIN_ADD_MEM, 1'b1, 1'b0, 1'b0, 8'h07, 8'h00, 8'h02, 8'h02, 8'h0a, 8'h02, 8'h01, 8'h01, 8'h00);
        run(F_BIN_SUB_MEM, 1'b0, 1'b0, 1'b0, 8'h07, 8'h00, 8'h02, 8'h02, 8'h0a, 8'h02, 8'h01, 8'h01, 8'h00);
        $display("test binary done");
    endtask

    task automatic t_quick_and_shift();
        run(F_MOVE_QUICK, 1'b0, 1'b0, 1'b0, 8'h07, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h01, 8'h00, 8'h00);
        run(F_SHIFT_IMM, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 8'h04, 8'h00, 8'h06, 8'h00, 8'h01, 8'h00, 8'h00);
        run(F_ROT_EXT_MEM, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 8'h00, 8'h02, 8'h06, 8'h00, 8'h01, 8'h01, 8'h00);
        $display("test quick and shift done");
    endtask

    task automatic t_long_and_imm();
        run(F_ADDQ_MEM, 1'b0, 1'b0, 1'b0, 8'h03, 8'h00, 8'h00, 8'h03, 8'h08, 8'h00, 8'h01, 8'h01, 8'h00);
        run(F_ADDQ_MEM, 1'b1, 1'b0, 1'b0, 8'h03, 8'h00, 8'h00, 8'h05, 8'h0a, 8'h00, 8'h01, 8'h02, 8'h00);
        run(F_IMM_MEM, 1'b0, 1'b0, 1'b0, 8'h02, 8'h04, 8'h00, 8'h03, 8'h0b, 8'h00, 8'h01, 8'h01, 8'h00);
        $display("test long and immediate done");
    endtask

    task automatic t_muldiv();
        run(F_MUL_LONG, 1'b0, 1'b0, 1'b1, 8'h04, 8'h00, 8'h02, 8'h00, 8'h3b, 8'h00, 8'h01, 8'h00, 8'h00);
        run(F_MUL_LONG, 1'b0, 1'b0, 1'b0, 8'h04, 8'h00, 8'h02, 8'h00, 8'h3b, 8'h00, 8'h01, 8'h00, 8'h00);
        run(F_DIVS_LONG, 1'b0, 1'b1, 1'b1, 8'h04, 8'h00, 8'h02, 8'h00, 8'h42, 8'h00, 8'h01, 8'h00, 8'h00);
        cmp("time_is_max", 8'h01, {7'h00, time_is_max});
        $display("test multiply and divide done");
    endtask

    task automatic t_wait_and_strap();
        run(F_DEC_ADD_MEM, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 8'h02, 8'h02, 8'h0c, 8'h02, 8'h01, 8'h01, 8'h03);
        cmp("timing_valid", 8'h01, {7'h00, timing_valid});
        @(posedge clk_sys);
        bus16_mode <= 1'b0;
        repeat (3) @(posedge clk_sys);
        run(F_MOVE_QUICK, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h01, 8'h00, 8'h00);
        cmp("timing_valid", 8'h00, {7'h00, timing_valid});
        @(posedge clk_sys);
        bus16_mode <= 1'b1;
        form <= ict_form_t'(6'h3f);
        start <= 1'b1;
        @(posedge clk_sys);
        start <= 1'b0;
        #1;
        cmp("form_known", 8'h00, {7'h00, form_known});
        cmp("busy", 8'h00, {7'h00, busy});
        $display("test wait and strap done");
    endtask

    // Pulls reset in the middle of a long instruction, checks that the report clears, then runs again.
    task automatic t_reset_midrun();
        @(posedge clk_sys);
        form <= F_MUL_LONG;
        src_is_dreg <= 1'b0;
        ea_clks <= 8'h04;
        start <= 1'b1;
        @(posedge clk_sys);
        start <= 1'b0;
        repeat (5) @(posedge clk_sys);
        rstn <= 1'b0;
        @(posedge clk_sys);
        #1;
        cmp("busy_in_reset", 8'h00, {7'h00, busy});
        cmp("head_in_reset", 8'h00, head_clks);
        cmp("total_in_reset", 8'h00, total_clks);
        cmp("elapsed_in_reset", 8'h00, elapsed_clks);
        cmp("max_in_reset", 8'h00, {7'h00, time_is_max});
        @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        cmp("busy_after_reset", 8'h00, {7'h00, busy});
        cmp("done_after_reset", 8'h00, {7'h00, done});
        run(F_MOVE_QUICK, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h01, 8'h00, 8'h00);
        $display("test reset done");
    endtask

    // Main sequence.
    initial begin
        fail_count = 0; total_checks = 0;
        rstn = 1'b0; start = 1'b0; form = F_MOVE_QUICK; is_long = 1'b0; src_is_dreg = 1'b0; is_signed = 1'b0;
        ea_clks = 8'h00; imm_clks = 8'h00; bus16_mode = 1'b1; stall_go = 1'b0; stall_len = 8'h00;
        repeat (4) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (2) @(posedge clk_sys);
        t_decimal();
        t_binary();
        t_quick_and_shift();
        t_long_and_imm();
        t_muldiv();
        t_wait_and_strap();
        t_reset_midrun();
        print_verdict();
    end
endmodule
